// ===== core/nba_alu.v
// What this block does
// - add, subtract, with carry and with borrow
// - register with memory or memory with immediate
// - decimal flag and no-store flag steer arithmetic
// - binary carry on overflow or borrow
// - stored arithmetic result zero sets zero flag
// - no-store blocks arithmetic write-back, flags still update
// - no-store zero keeps zero flag, else clear
// - no-store still sets carry on overflow
// - decimal carry above nine or below zero
// - binary first, then decimal correction
// - out-of-range decimal gives carry and big nibble
// - decimal correction follows fixed table
// - no-store plus decimal updates flags only
// - write-back to status word overwrites flags
// - no-store on status word keeps proper flags
// - bitwise or, and, xor in both forms
// - logic ignores modes, keeps flags except on status word
// - index flag offsets memory operand address
// - carry feeds the low bit position
// - result goes to the first operand location
//
// Implementation choices: the address map and register access over AXI4-Lite.
`include "nba_map.vh"
module nba_alu
#(
  parameter RA_W     = 4,
  parameter MA_W     = 7,
  parameter [MA_W-1:0] PSW_ADDR = `NBA_PSW_ADDR
)
(
  // clock and reset
  input  wire            mclk,
  input  wire            sys_rst,
  // axi4-lite write address
  input  wire [3:0]      s_axi_awaddr,
  input  wire            s_axi_awvalid,
  output reg             s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]     s_axi_wdata,
  input  wire [3:0]      s_axi_wstrb,
  input  wire            s_axi_wvalid,
  output reg             s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]      s_axi_bresp,
  output reg             s_axi_bvalid,
  input  wire            s_axi_bready,
  // axi4-lite read address
  input  wire [3:0]      s_axi_araddr,
  input  wire            s_axi_arvalid,
  output reg             s_axi_arready,
  // axi4-lite read data
  output reg  [31:0]     s_axi_rdata,
  output reg  [1:0]      s_axi_rresp,
  output reg             s_axi_rvalid,
  input  wire            s_axi_rready,
  // operation request from the decoder
  input  wire            op_valid,
  output reg             op_ready,
  input  wire [2:0]      op_code,
  input  wire            op_form,
  input  wire [RA_W-1:0] op_reg_addr,
  input  wire [MA_W-1:0] op_mem_addr,
  input  wire [3:0]      op_imm,
  input  wire [3:0]      reg_rd_data,
  // data memory operand read
  output reg  [MA_W-1:0] mem_rd_addr,
  input  wire [3:0]      mem_rd_data,
  // result write-back
  output reg             wb_reg_we,
  output reg             wb_mem_we,
  output reg  [RA_W-1:0] wb_reg_addr,
  output reg  [MA_W-1:0] wb_mem_addr,
  output reg  [3:0]      wb_data,
  // status word flags and control register decimal flag
  output reg             carry_flag,
  output reg             result_null_flag,
  output reg             compare_no_store_flag,
  output reg             decimal_mode_flag,
  output reg             index_enable_flag
);

  // captured request
  reg            state_reg;
  reg [2:0]      code_reg;
  reg            form_reg;
  reg [RA_W-1:0] raddr_reg;
  reg [3:0]      imm_reg;
  reg [3:0]      rdat_reg;
  reg [MA_W-1:0] index_reg;
  localparam     ST_IDLE = `NBA_ST_IDLE;
  localparam     ST_EXEC = `NBA_ST_EXEC;
  // axi holding registers
  reg            aw_hold_reg;
  reg            w_hold_reg;
  reg [3:0]      aw_addr_reg;
  reg [31:0]     w_data_reg;
  reg            w_lane_reg;
  // indexed memory address
  wire [MA_W:0]   idx_sum = {1'b0, op_mem_addr} + {1'b0, index_reg};
  wire [MA_W-1:0] eff_addr = index_enable_flag ? idx_sum[MA_W-1:0] : op_mem_addr;
  // operand selection
  wire [3:0] opa = (form_reg == `NBA_FORM_MEM_IMM) ? mem_rd_data : rdat_reg;
  wire [3:0] opb = (form_reg == `NBA_FORM_MEM_IMM) ? imm_reg : mem_rd_data;
  wire is_arith = ~code_reg[2];
  wire is_sub   = code_reg[1];
  wire use_cy   = code_reg[0] & carry_flag;
  // binary arithmetic, bit 4 is carry or borrow
  wire [4:0] add_bin = {1'b0, opa} + {1'b0, opb} + {4'h0, use_cy};
  wire [4:0] sub_bin = {1'b0, opa} - {1'b0, opb} - {4'h0, use_cy};
  wire [4:0] bin_res = is_sub ? sub_bin : add_bin;
  wire [3:0] dec_nib;
  wire       dec_carry;
  nba_dec_corr u_dec_corr
  (
    .bin_in    (bin_res),
    .is_sub    (is_sub),
    .dec_nib   (dec_nib),
    .dec_carry (dec_carry)
  );
  // arithmetic result and carry
  wire [3:0] ar_nib = decimal_mode_flag ? dec_nib : bin_res[3:0];
  wire       ar_cy  = decimal_mode_flag ? dec_carry : bin_res[4];
  // logical result, the spare code acts as xor
  wire [3:0] lg_nib = (code_reg == `NBA_OP_OR)  ? (opa | opb) :
                      (code_reg == `NBA_OP_AND) ? (opa & opb) : (opa ^ opb);
  wire [3:0] res_nib = is_arith ? ar_nib : lg_nib;
  wire       exec    = (state_reg == ST_EXEC);
  wire       store   = ~is_arith | ~compare_no_store_flag;
  wire       to_mem  = (form_reg == `NBA_FORM_MEM_IMM);
  wire       to_psw  = exec & store & to_mem & (mem_rd_addr == PSW_ADDR);
  // zero flag next value
  wire zero_hit  = (ar_nib == `NBA_RST_NIB);
  wire zero_next = compare_no_store_flag ? (zero_hit & result_null_flag) : zero_hit;
  // axi decode
  wire do_write = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
  wire wr_ctrl  = do_write & w_lane_reg & (aw_addr_reg == `NBA_OFS_CTRL);
  wire wr_stat  = do_write & w_lane_reg & (aw_addr_reg == `NBA_OFS_STATUS);
  wire wr_index = do_write & w_lane_reg & (aw_addr_reg == `NBA_OFS_INDEX);
  wire wr_known = (aw_addr_reg == `NBA_OFS_CTRL) | (aw_addr_reg == `NBA_OFS_STATUS) |
                  (aw_addr_reg == `NBA_OFS_INDEX) | (aw_addr_reg == `NBA_OFS_RESULT);
  // request sequencer
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg   <= ST_IDLE;
      op_ready    <= 1'b1;
      code_reg    <= `NBA_OP_ADD;
      form_reg    <= `NBA_FORM_REG_MEM;
      raddr_reg   <= {RA_W{1'b0}};
      imm_reg     <= `NBA_RST_NIB;
      rdat_reg    <= `NBA_RST_NIB;
      mem_rd_addr <= {MA_W{1'b0}};
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (op_valid)
          begin
            state_reg   <= ST_EXEC;
            op_ready    <= 1'b0;
            code_reg    <= op_code;
            form_reg    <= op_form;
            raddr_reg   <= op_reg_addr;
            imm_reg     <= op_imm;
            rdat_reg    <= reg_rd_data;
            mem_rd_addr <= eff_addr;
          end
        end
        ST_EXEC:
        begin
          state_reg <= ST_IDLE;
          op_ready  <= 1'b1;
        end
        default:
        begin
          state_reg <= ST_IDLE;
          op_ready  <= 1'b1;
        end
      endcase
    end
  end
  // write-back
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wb_reg_we   <= 1'b0;
      wb_mem_we   <= 1'b0;
      wb_reg_addr <= {RA_W{1'b0}};
      wb_mem_addr <= {MA_W{1'b0}};
      wb_data     <= `NBA_RST_NIB;
    end
    else
    begin
      wb_reg_we <= exec & store & ~to_mem;
      wb_mem_we <= exec & store & to_mem;
      if (exec)
      begin
        wb_reg_addr <= raddr_reg;
        wb_mem_addr <= mem_rd_addr;
        wb_data     <= res_nib;
      end
    end
  end

  // status word and control; hardware update wins over a software write
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      carry_flag            <= `NBA_RST_BIT;
      result_null_flag      <= `NBA_RST_BIT;
      compare_no_store_flag <= `NBA_RST_BIT;
      index_enable_flag     <= `NBA_RST_BIT;
      decimal_mode_flag     <= `NBA_RST_BIT;
      index_reg             <= {MA_W{1'b0}};
    end
    else
    begin
      if (wr_stat)
      begin
        carry_flag            <= w_data_reg[`NBA_ST_CARRY];
        result_null_flag      <= w_data_reg[`NBA_ST_ZERO];
        compare_no_store_flag <= w_data_reg[`NBA_ST_CMP];
        index_enable_flag     <= w_data_reg[`NBA_ST_IXE];
      end
      if (wr_ctrl)
        decimal_mode_flag <= w_data_reg[`NBA_CTRL_DEC];
      if (wr_index)
        index_reg <= w_data_reg[MA_W-1:0];
      if (exec & is_arith)
      begin
        carry_flag       <= ar_cy;
        result_null_flag <= zero_next;
      end
      if (to_psw)
      begin
        carry_flag            <= res_nib[`NBA_ST_CARRY];
        result_null_flag      <= res_nib[`NBA_ST_ZERO];
        compare_no_store_flag <= res_nib[`NBA_ST_CMP];
        index_enable_flag     <= res_nib[`NBA_ST_IXE];
      end
    end
  end

  // axi write channels
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `NBA_RESP_OKAY;
      aw_hold_reg   <= 1'b0;
      w_hold_reg    <= 1'b0;
      aw_addr_reg   <= 4'h0;
      w_data_reg    <= 32'h0;
      w_lane_reg    <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_hold_reg   <= 1'b1;
        aw_addr_reg   <= {s_axi_awaddr[3:2], 2'h0};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_hold_reg   <= 1'b1;
        w_data_reg   <= s_axi_wdata;
        w_lane_reg   <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `NBA_RESP_OKAY : `NBA_RESP_SLVERR;
      end
      if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // axi read channels
  reg [31:0] rd_mux;
  always @*
  begin
    rd_mux = 32'h0;
    case ({s_axi_araddr[3:2], 2'h0})
      `NBA_OFS_CTRL:   rd_mux[`NBA_CTRL_DEC] = decimal_mode_flag;
      `NBA_OFS_STATUS: rd_mux[3:0] = {compare_no_store_flag, carry_flag,
                                      result_null_flag, index_enable_flag};
      `NBA_OFS_INDEX:  rd_mux[MA_W-1:0] = index_reg;
      `NBA_OFS_RESULT: rd_mux[3:0] = wb_data;
      default:         rd_mux = 32'h0;
    endcase
  end

  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `NBA_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= `NBA_RESP_OKAY;
      end
      else if (s_axi_rvalid & s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // nba_alu

// ===== core/nba_dec_corr.v
`include "nba_map.vh"

module nba_dec_corr
(
  // binary result with carry or borrow in bit 4
  input  wire [4:0] bin_in,
  input  wire       is_sub,
  // corrected nibble
  output reg  [3:0] dec_nib,
  output reg        dec_carry
);

  always @*
  begin
    dec_carry = 1'b1;
    dec_nib   = bin_in[3:0];
    if (!is_sub)
    begin
      if (bin_in <= `NBA_DEC_MAX)
      begin
        dec_carry = 1'b0;
      end
      else if (bin_in <= `NBA_DEC_ADD_HI)
      begin
        dec_nib = bin_in[3:0] - `NBA_DEC_TEN;
      end
      else
      begin
        case (bin_in[3:0])
          4'h4, 4'h8: dec_nib = 4'he;
          4'h5, 4'h9: dec_nib = 4'hf;
          4'h6, 4'ha, 4'he: dec_nib = 4'hc;
          4'h7, 4'hb, 4'hf: dec_nib = 4'hd;
          4'hc: dec_nib = 4'ha;
          4'hd: dec_nib = 4'hb;
          default: dec_nib = 4'he;
        endcase
      end
    end
    else
    begin
      if (bin_in <= `NBA_DEC_MAX)
      begin
        dec_carry = 1'b0;
      end
      else if (bin_in[4] && bin_in[3:0] >= `NBA_SUB_NEG_LO)
      begin
        dec_nib = bin_in[3:0] - `NBA_SUB_NEG_LO;
      end
      else
      begin
        dec_nib = {`NBA_DEC_BIG_TOP, bin_in[1:0] + `NBA_DEC_BIG_ADJ};
      end
    end
  end

endmodule // nba_dec_corr

// ===== core/nba_map.vh
`ifndef NBA_MAP_VH
`define NBA_MAP_VH

// operation codes from the decoder
`define NBA_OP_ADD        3'h0
`define NBA_OP_SUM_WITH_CARRY_IN       3'h1
`define NBA_OP_SUB        3'h2
`define NBA_OP_DIFFERENCE_WITH_BORROW_IN       3'h3
`define NBA_OP_OR         3'h4
`define NBA_OP_AND        3'h5
`define NBA_OP_XOR        3'h6

// operand forms
`define NBA_FORM_REG_MEM  1'b0
`define NBA_FORM_MEM_IMM  1'b1

// register byte offsets
`define NBA_OFS_CTRL      4'h0
`define NBA_OFS_STATUS    4'h4
`define NBA_OFS_INDEX     4'h8
`define NBA_OFS_RESULT    4'hc

// control register field
`define NBA_CTRL_DEC      0

// status word fields
`define NBA_ST_IXE        0
`define NBA_ST_ZERO       1
`define NBA_ST_CARRY      2
`define NBA_ST_CMP        3

// status word location in data memory
`define NBA_PSW_ADDR      7'h7f

// reset values
`define NBA_RST_NIB       4'h0
`define NBA_RST_BIT       1'b0

// axi responses
`define NBA_RESP_OKAY     2'h0
`define NBA_RESP_SLVERR   2'h2

// decimal limits
`define NBA_DEC_MAX       5'h09
`define NBA_DEC_ADD_HI    5'h13
`define NBA_DEC_TEN       4'ha
`define NBA_SUB_NEG_LO    4'h6
`define NBA_DEC_BIG_TOP   2'h3
`define NBA_DEC_BIG_ADJ   2'h2

// sequencer states
`define NBA_ST_IDLE       1'b0
`define NBA_ST_EXEC       1'b1

`endif

// ===== verif/nba_alu_monitor.sv
module nba_alu_monitor
#(
  parameter RA_W = 4
)
(
  // clock and reset
  input wire            mclk,
  input wire            sys_rst,
  // operation request
  input wire            op_valid,
  input wire            op_ready,
  input wire [2:0]      op_code,
  input wire            op_form,
  input wire [RA_W-1:0] op_reg_addr,
  // write-back and flags
  input wire            wb_reg_we,
  input wire            wb_mem_we,
  input wire [RA_W-1:0] wb_reg_addr,
  input wire [3:0]      wb_data,
  input wire            carry_flag,
  input wire            result_null_flag,
  input wire            compare_no_store_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence take_s; op_valid && op_ready; endsequence
  sequence arith_s; take_s ##0 !op_code[2]; endsequence
  sequence store_s; take_s ##0 (op_code[2] || !compare_no_store_flag); endsequence
  op_busy_a: assert property (take_s |=> !op_ready ##1 op_ready)
    else $error("op_ready pattern wrong");
  we_pulse_a: assert property (wb_reg_we || wb_mem_we |=> !wb_reg_we && !wb_mem_we)
    else $error("write pulse too long");
  no_store_a: assert property (arith_s ##0 compare_no_store_flag |=> ##1 !wb_reg_we && !wb_mem_we)
    else $error("write in no-store mode");
  reg_store_a: assert property (store_s ##0 !op_form |=> ##1 wb_reg_we && !wb_mem_we
    && wb_reg_addr == $past(op_reg_addr, 2))
    else $error("register write-back wrong");
  mem_store_a: assert property (store_s ##0 op_form |=> ##1 wb_mem_we && !wb_reg_we)
    else $error("memory write-back wrong");
  logic_flags_a: assert property (take_s ##0 op_code[2] && !op_form |=> ##1
    carry_flag == $past(carry_flag, 2) && result_null_flag == $past(result_null_flag, 2))
    else $error("logic op changed flags");
  zero_set_a: assert property (arith_s ##0 !compare_no_store_flag && !op_form |=> ##1
    result_null_flag == (wb_data == 4'h0))
    else $error("zero flag wrong");
  zero_hold_a: assert property (arith_s ##0 compare_no_store_flag |=> ##1
    !result_null_flag || $past(result_null_flag, 2))
    else $error("zero flag set in no-store mode");
endmodule // nba_alu_monitor

bind nba_alu nba_alu_monitor #(.RA_W(RA_W)) mon (.mclk, .sys_rst, .op_valid, .op_ready,
  .op_code, .op_form, .op_reg_addr, .wb_reg_we, .wb_mem_we, .wb_reg_addr, .wb_data,
  .carry_flag, .result_null_flag, .compare_no_store_flag);

// ===== verif/nba_mem_model.sv
module nba_mem_model
(
  // clock
  input  wire        mclk,
  // operand read
  input  wire [6:0]  mem_rd_addr,
  output logic [3:0] mem_rd_data,
  // result write
  input  wire        wb_mem_we,
  input  wire [6:0]  wb_mem_addr,
  input  wire [3:0]  wb_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] m [0:127];
  // memory operand, first or second by form
  assign mem_rd_data = m[mem_rd_addr];
  // result lands at the first operand location
  always @(posedge mclk)
    if (wb_mem_we)
      m[wb_mem_addr] <= wb_data;
endmodule // nba_mem_model

// ===== verif/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // clock, reset, register bus
  logic        mclk = 0, sys_rst = 1;
  logic [3:0]  s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  // operation port
  logic        op_valid = 0, op_form = 0, op_ready;
  logic [2:0]  op_code = '0;
  logic [3:0]  op_reg_addr = 4'h3, op_imm = '0, reg_rd_data = '0, mem_rd_data;
  logic [6:0]  op_mem_addr = 7'h0a, mem_rd_addr, wb_mem_addr, ix = '0;
  logic [3:0]  wb_reg_addr, wb_data;
  logic        wb_reg_we, wb_mem_we, carry_flag, result_null_flag;
  logic        compare_no_store_flag, decimal_mode_flag, index_enable_flag;
  logic [3:0]  lr [3] = '{4'he, 4'h8, 4'h6};
  int          fails = 0, comparisons = 0;

  always #20 mclk = ~mclk;

  nba_alu uut (.mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .op_valid, .op_ready,
    .op_code, .op_form, .op_reg_addr, .op_mem_addr, .op_imm, .reg_rd_data,
    .mem_rd_addr, .mem_rd_data, .wb_reg_we, .wb_mem_we, .wb_reg_addr, .wb_mem_addr,
    .wb_data, .carry_flag, .result_null_flag, .compare_no_store_flag,
    .decimal_mode_flag, .index_enable_flag);
  nba_mem_model mdl (.mclk, .mem_rd_addr, .mem_rd_data, .wb_mem_we, .wb_mem_addr, .wb_data);

  task test_done;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask

  task wait_bound(input int n);
    if (n > 49)
    begin
      chk("timeout", 0, 1);
      test_done;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do
    begin
      @(posedge mclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 0;
      if (s_axi_wready)
        s_axi_wvalid <= 0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 0;
    wait_bound(n);
    chk("bresp", 0, s_axi_bresp);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    int n = 0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do
    begin
      @(posedge mclk);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 0;
    wait_bound(n);
    chk("rdata", e, s_axi_rdata);
    chk("rresp", 0, s_axi_rresp);
  endtask

  // one operation; ew 0 no write, 1 write and data, 2 write only
  task automatic t(input logic [2:0] c, input logic f, input logic [3:0] a, b, r,
                   input logic ec, ez, input int ew);
    int n = 0;
    @(posedge mclk);
    op_valid <= 1;
    op_code <= c;
    op_form <= f;
    reg_rd_data <= a;
    op_imm <= b;
    do
    begin
      @(posedge mclk);
      n++;
    end while (!op_ready && n < 50);
    op_valid <= 0;
    mdl.m[ix + 7'd10] <= f ? a : b;
    wait_bound(n);
    @(posedge mclk);
    #1;
    if (ew == 0)
      chk("no write", 0, wb_reg_we | wb_mem_we);
    else
      chk("write", 1, f ? wb_mem_we : wb_reg_we);
    if (ew == 1)
      chk("result", r, wb_data);
    chk("carry", ec, carry_flag);
    chk("zero", ez, result_null_flag);
  endtask

  initial
  begin
    repeat (2) @(posedge mclk);
    sys_rst <= 0;
    rd(4'h4, 0);
    t(3'h0, 0, 4'h9, 4'h7, 4'h0, 1, 1, 1);
    t(3'h1, 0, 4'h0, 4'h0, 4'h1, 0, 0, 1);
    t(3'h2, 1, 4'h3, 4'h5, 4'he, 1, 0, 1);
    t(3'h3, 1, 4'h5, 4'h2, 4'h2, 0, 0, 1);
    wr(4'h4, 32'ha);
    t(3'h2, 1, 4'h1, 4'h1, 4'h0, 0, 1, 0);
    t(3'h2, 1, 4'h1, 4'h2, 4'h0, 1, 0, 0);
    t(3'h2, 0, 4'h1, 4'h1, 4'h0, 0, 0, 0);
    wr(4'h0, 32'h1);
    wr(4'h4, 32'h0);
    chk("decimal", 1, decimal_mode_flag);
    t(3'h0, 0, 4'h9, 4'h8, 4'h7, 1, 0, 1);
    t(3'h0, 1, 4'h5, 4'h5, 4'h0, 1, 1, 1);
    t(3'h0, 0, 4'h9, 4'h0, 4'h9, 0, 0, 1);
    t(3'h2, 0, 4'h3, 4'h5, 4'h8, 1, 0, 1);
    t(3'h0, 0, 4'ha, 4'ha, 4'he, 1, 0, 1);
    t(3'h2, 0, 4'h0, 4'hf, 4'hf, 1, 0, 1);
    chk("big", 1, wb_data >= 4'ha);
    wr(4'h4, 32'ha);
    t(3'h2, 1, 4'h3, 4'h1, 4'h0, 0, 0, 0);
    t(3'h3, 1, 4'h0, 4'h1, 4'h0, 1, 0, 0);
    wr(4'h0, 32'h0);
    ix = 7'd117;
    wr(4'h8, 32'd117);
    wr(4'h4, 32'h1);
    t(3'h0, 1, 4'h0, 4'h4, 4'h4, 1, 0, 1);
    chk("index flag", 0, index_enable_flag);
    wr(4'h4, 32'hb);
    t(3'h0, 1, 4'h0, 4'h4, 4'h0, 0, 0, 0);
    wr(4'h0, 32'h1);
    ix = 7'd5;
    wr(4'h8, 32'h5);
    wr(4'h4, 32'hf);
    for (int k = 0; k < 6; k++)
      t(3'(4 + k / 2), 1'(k % 2), 4'hc, 4'ha, lr[k / 2], 1, 1, 1);
    chk("mem addr", 15, wb_mem_addr);
    wr(4'hc, 32'h5);
    rd(4'hc, 6);
    rd(4'h4, 32'hf);
    rd(4'h8, 5);
    test_done;
  end
endmodule // testbench
